//--- hdl/ssm_pkg.sv
// Package of constants and types for the safe stop monitor
// Summary of operation
// - Stop one: watch stop time, then cut torque
// - Standstill when speed below tolerance window
// - Restart allowed only after stop time elapsed; a plain cutoff from run needs none
// - Stop one mode: 0 after time, 1 at standstill
// - Encoder and mode 1: delay before cutoff
// - No encoder: inverter status, at most 5 rpm
// - Start from bus, error stop or emergency
// - Normal end cuts torque by stopping field
// - No standstill at timeout: error stop, cutoff
// - Ramp exceeded while monitored: error stop
// - Error stop continues after request withdrawn
// - Raw bus stop bits readable unchanged
// - Encoder response time 12, 50 or 100 ms
// - Bus source enable for stop one requests
// - Stop hold: check standstill, then enter hold
// - Standstill hold keeps torque and control loops
// - Optional deceleration ramp monitored in stop one and stop hold when an encoder is present
// - Torque cutoff highest priority, clears status bit 15
// - Stop hold mode: 0 after time, 1 at standstill
// - Restart after cutoff: 0 acknowledged, 1 automatic
package ssm_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam logic [16:0] MS_CNT_LAST = 17'(CYC_PER_MS - 1);

	localparam logic [15:0] NO_ENC_STILL_RPM = 16'h0005;

	localparam logic [15:0] REG_BUS_BITS = 16'h2875;
	localparam logic [15:0] REG_ENC_RESP = 16'h2878;
	localparam logic [15:0] REG_SPD_WIN = 16'h287b;
	localparam logic [15:0] REG_STOP_TIME = 16'h2894;
	localparam logic [15:0] REG_S1_SRC = 16'h2896;
	localparam logic [15:0] REG_S1_MODE = 16'h2897;
	localparam logic [15:0] REG_S1_DELAY = 16'h2898;
	localparam logic [15:0] REG_S2_MODE = 16'h2899;
	localparam logic [15:0] REG_RESTART = 16'h289a;
	localparam logic [15:0] REG_ENC_CFG = 16'h289c;
	localparam logic [15:0] REG_RAMP = 16'h289d;
	localparam logic [15:0] REG_STATUS = 16'h28a0;
	localparam logic [15:0] REG_PARAM_UNLOCK = 16'h28a1;

	localparam logic [31:0] UNLOCK_KEY = 32'h5afe_0001;

	localparam logic [7:0] ENC_RESP_12 = 8'h0c;
	localparam logic [7:0] ENC_RESP_50 = 8'h32;
	localparam logic [7:0] ENC_RESP_100 = 8'h64;

	localparam logic [7:0] RST_ENC_RESP = 8'h0c;
	localparam logic [15:0] RST_SPD_WIN = 16'h000a;
	localparam logic [15:0] RST_STOP_TIME = 16'h03e8;
	localparam logic [15:0] RST_S1_DELAY = 16'h000a;

	localparam int STAT_TORQUE_ON = 15;

	typedef enum logic [4:0] {
		SSM_RUN = 5'b0_0001,
		SSM_STOP1 = 5'b0_0010,
		SSM_STOP2 = 5'b0_0100,
		SSM_HOLD = 5'b0_1000,
		SSM_CUTOFF = 5'b1_0000
	} ssm_state_t;

	typedef struct packed {
		logic cutoff;
		logic stop_one;
		logic stop_hold;
		logic emergency;
	} ssm_bus_bits_t;

	typedef struct packed {
		logic [15:0] speed;
		logic still_status;
		logic ramp_exceeded;
	} ssm_drive_t;
endpackage : ssm_pkg

//--- hdl/ssm_safe_stop_monitor.sv
// Safe stop monitor: stop one, stop hold and torque cutoff sequencing
`timescale 1ns/1ns
module ssm_safe_stop_monitor
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [17:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Safety bus and drive
	input wire ssm_pkg::ssm_bus_bits_t bus_bits_i,
	input wire logic error_stop_req_i,
	input wire ssm_pkg::ssm_drive_t drive_i,
	input wire logic restart_ack_i,
	// Drive control
	output logic torque_cutoff_o,
	output logic standstill_hold_o,
	output logic error_o,
	output logic restart_ok_o,
	output logic [15:0] status_word_o
);
	import ssm_pkg::*;

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [7:0] enc_resp_r;
	logic [15:0] spd_win_r;
	logic [15:0] stop_time_r;
	logic s1_src_r;
	logic s1_mode_r;
	logic [15:0] s1_delay_r;
	logic s2_mode_r;
	logic restart_auto_r;
	logic enc_present_r;
	logic ramp_en_r;
	logic unlock_r;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [17:0] a, input logic [15:0] reg_idx);
		hit = (a[17:2] == reg_idx) && (a[1:0] == 2'b00);
	endfunction : hit

	wire logic access = psel_i && penable_i;
	wire logic wr = access && pwrite_i;
	wire logic wr_cfg = wr && unlock_r;
	wire logic hit_bits = hit(paddr_i, REG_BUS_BITS);
	wire logic hit_enc = hit(paddr_i, REG_ENC_RESP);
	wire logic hit_win = hit(paddr_i, REG_SPD_WIN);
	wire logic hit_time = hit(paddr_i, REG_STOP_TIME);
	wire logic hit_src = hit(paddr_i, REG_S1_SRC);
	wire logic hit_mode = hit(paddr_i, REG_S1_MODE);
	wire logic hit_dly = hit(paddr_i, REG_S1_DELAY);
	wire logic hit_s2 = hit(paddr_i, REG_S2_MODE);
	wire logic hit_rst = hit(paddr_i, REG_RESTART);
	wire logic hit_ecfg = hit(paddr_i, REG_ENC_CFG);
	wire logic hit_ramp = hit(paddr_i, REG_RAMP);
	wire logic hit_stat = hit(paddr_i, REG_STATUS);
	wire logic hit_unl = hit(paddr_i, REG_PARAM_UNLOCK);
	wire logic mapped = hit_bits | hit_enc | hit_win | hit_time | hit_src | hit_mode | hit_dly
		| hit_s2 | hit_rst | hit_ecfg | hit_ramp | hit_stat | hit_unl;
	// Writes to settings refused while locked: they stay read-only
	wire logic cfg_reg = hit_enc | hit_win | hit_time | hit_src | hit_mode | hit_dly | hit_s2
		| hit_rst | hit_ecfg | hit_ramp;
	wire logic ro_fault = pwrite_i && (hit_bits || hit_stat || (cfg_reg && !unlock_r));
	wire logic enc_legal = (pwdata_i[7:0] == ENC_RESP_12) || (pwdata_i[7:0] == ENC_RESP_50)
		|| (pwdata_i[7:0] == ENC_RESP_100);
	wire logic enc_bad = pwrite_i && hit_enc && !enc_legal;

	// ------------------------------------------------------------
	// Millisecond tick and counters
	// ------------------------------------------------------------
	logic [16:0] div_r;
	wire logic ms_tick = (div_r == MS_CNT_LAST);
	logic [15:0] stop_ms_r;
	logic [15:0] delay_ms_r;
	ssm_state_t state_r;
	ssm_state_t state_nxt;
	logic err_stop_r;
	logic time_done_r;

	// Standstill judgement
	wire logic still_enc = drive_i.speed < spd_win_r;
	wire logic still_inv = drive_i.still_status || (drive_i.speed <= NO_ENC_STILL_RPM);
	wire logic standstill = enc_present_r ? still_enc : still_inv;

	// Request sources
	wire logic req_cutoff = bus_bits_i.cutoff;
	wire logic req_s1 = (bus_bits_i.stop_one && s1_src_r) || bus_bits_i.emergency
		|| error_stop_req_i;
	wire logic req_s2 = bus_bits_i.stop_hold;
	wire logic stopping = (state_r == SSM_STOP1) || (state_r == SSM_STOP2);
	// Stop time keeps running after an early cutoff, so a restart still waits for it
	wire logic elapsed = (state_r != SSM_RUN) && (stop_ms_r >= stop_time_r);
	wire logic time_up = stopping && elapsed;
	wire logic time_fail = time_up && !standstill;
	wire logic ramp_fail = stopping && ramp_en_r && enc_present_r && drive_i.ramp_exceeded;
	wire logic delay_done = (!enc_present_r) || (delay_ms_r >= s1_delay_r);
	wire logic s1_cut_now = s1_mode_r ? (standstill && delay_done) : 1'b0;
	wire logic s1_end = time_up || s1_cut_now;
	wire logic s2_end = time_up || (s2_mode_r && standstill);
	wire logic fail = time_fail || ramp_fail;
	wire logic any_req = req_cutoff || req_s1 || req_s2 || err_stop_r;
	wire logic restart_allow = time_done_r && !any_req && (restart_auto_r || restart_ack_i);

	// ------------------------------------------------------------
	// Stop sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			SSM_RUN:
				if (req_cutoff)
					state_nxt = SSM_CUTOFF;
				else if (req_s1)
					state_nxt = SSM_STOP1;
				else if (req_s2)
					state_nxt = SSM_STOP2;
			SSM_STOP1:
				if (req_cutoff || fail || s1_end)
					state_nxt = SSM_CUTOFF;
				else if (!req_s1 && !err_stop_r && !req_s2)
					state_nxt = SSM_STOP1; // no early return, time must elapse
			SSM_STOP2:
				if (req_cutoff || fail)
					state_nxt = SSM_CUTOFF;
				else if (req_s1)
					state_nxt = SSM_STOP1; // Stop one outranks stop hold
				else if (s2_end)
					state_nxt = SSM_HOLD;
			SSM_HOLD:
				if (req_cutoff || req_s1)
					state_nxt = (req_cutoff) ? SSM_CUTOFF : SSM_STOP1;
				else if (!req_s2 && restart_allow)
					state_nxt = SSM_RUN;
			SSM_CUTOFF:
				if (restart_allow)
					state_nxt = SSM_RUN;
			default:
				state_nxt = SSM_CUTOFF;
		endcase
	end

	// A new stop re-arms the stop time; a plain cutoff has no stop time to wait for
	wire logic stop_entry = ((state_nxt == SSM_STOP1) && (state_r != SSM_STOP1))
		|| ((state_nxt == SSM_STOP2) && (state_r != SSM_STOP2));
	wire logic sto_entry = (state_r == SSM_RUN) && (state_nxt == SSM_CUTOFF);

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			div_r <= '0;
		else
			div_r <= ms_tick ? '0 : div_r + 17'h0_0001;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			state_r <= SSM_RUN;
			stop_ms_r <= '0;
			delay_ms_r <= '0;
			err_stop_r <= 1'b0;
			time_done_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			// Counter from acceptance, cleared back in run or on a new stop
			if (state_r == SSM_RUN || stop_entry)
				stop_ms_r <= '0;
			else if (ms_tick && !elapsed)
				stop_ms_r <= stop_ms_r + 16'h0001;
			if (!(state_r == SSM_STOP1 && standstill))
				delay_ms_r <= '0;
			else if (ms_tick && delay_ms_r != 16'hffff)
				delay_ms_r <= delay_ms_r + 16'h0001;
			// Error stop latched until acknowledged in cutoff so a withdrawn request cannot end it
			if (fail)
				err_stop_r <= 1'b1;
			else if (state_r == SSM_CUTOFF && restart_ack_i && !error_stop_req_i)
				err_stop_r <= 1'b0;
			// Stale elapsed time of an aborted stop must not free the new one
			if (stop_entry)
				time_done_r <= 1'b0;
			else if (elapsed || sto_entry)
				time_done_r <= 1'b1;
			else if (state_r == SSM_RUN)
				time_done_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			torque_cutoff_o <= 1'b0;
			standstill_hold_o <= 1'b0;
			error_o <= 1'b0;
			restart_ok_o <= 1'b0;
			status_word_o <= 16'h8000;
		end
		else
		begin
			torque_cutoff_o <= (state_nxt == SSM_CUTOFF);
			standstill_hold_o <= (state_nxt == SSM_HOLD);
			error_o <= err_stop_r || fail;
			restart_ok_o <= restart_allow;
			status_word_o <= '0;
			status_word_o[STAT_TORQUE_ON] <= (state_nxt != SSM_CUTOFF);
			status_word_o[0] <= (state_nxt == SSM_STOP1);
			status_word_o[1] <= (state_nxt == SSM_STOP2);
			status_word_o[2] <= (state_nxt == SSM_HOLD);
			status_word_o[3] <= standstill;
			status_word_o[4] <= err_stop_r || fail;
		end
	end

	// ------------------------------------------------------------
	// APB registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			enc_resp_r <= RST_ENC_RESP;
			spd_win_r <= RST_SPD_WIN;
			stop_time_r <= RST_STOP_TIME;
			s1_src_r <= 1'b1;
			s1_mode_r <= 1'b0;
			s1_delay_r <= RST_S1_DELAY;
			s2_mode_r <= 1'b0;
			restart_auto_r <= 1'b0;
			enc_present_r <= 1'b0;
			ramp_en_r <= 1'b0;
			unlock_r <= 1'b0;
		end
		else if (wr && !ro_fault && !enc_bad)
		begin
			if (hit_unl)
				unlock_r <= (pwdata_i == UNLOCK_KEY);
			if (wr_cfg && hit_enc)
				enc_resp_r <= pwdata_i[7:0];
			if (wr_cfg && hit_win)
				spd_win_r <= pwdata_i[15:0];
			if (wr_cfg && hit_time)
				stop_time_r <= pwdata_i[15:0];
			if (wr_cfg && hit_src)
				s1_src_r <= pwdata_i[0];
			if (wr_cfg && hit_mode)
				s1_mode_r <= pwdata_i[0];
			if (wr_cfg && hit_dly)
				s1_delay_r <= pwdata_i[15:0];
			if (wr_cfg && hit_s2)
				s2_mode_r <= pwdata_i[0];
			if (wr_cfg && hit_rst)
				restart_auto_r <= pwdata_i[0];
			if (wr_cfg && hit_ecfg)
				enc_present_r <= pwdata_i[0];
			if (wr_cfg && hit_ramp)
				ramp_en_r <= pwdata_i[0];
		end
	end

	wire logic [31:0] rdata =
		hit_bits ? {28'h000_0000, bus_bits_i} :
		hit_enc ? {24'h00_0000, enc_resp_r} :
		hit_win ? {16'h0000, spd_win_r} :
		hit_time ? {16'h0000, stop_time_r} :
		hit_src ? {31'h0, s1_src_r} :
		hit_mode ? {31'h0, s1_mode_r} :
		hit_dly ? {16'h0000, s1_delay_r} :
		hit_s2 ? {31'h0, s2_mode_r} :
		hit_rst ? {31'h0, restart_auto_r} :
		hit_ecfg ? {31'h0, enc_present_r} :
		hit_ramp ? {31'h0, ramp_en_r} :
		hit_stat ? {16'h0000, status_word_o} :
		hit_unl ? {31'h0, unlock_r} : 32'h0000_0000;

	// No wait state: ready in the cycle after setup
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			pready_o <= 1'b0;
			prdata_o <= '0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o <= psel_i && !penable_i;
			prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rdata : 32'h0000_0000;
			pslverr_o <= psel_i && !penable_i && (!mapped || ro_fault || enc_bad);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_cutoff_priority: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		req_cutoff |=> torque_cutoff_o && !status_word_o[STAT_TORQUE_ON])
		else $error("cutoff request not honoured");
	a_timeout_error: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		time_fail |=> torque_cutoff_o && error_o)
		else $error("timeout without standstill not cut");
	a_hold_torque: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_r == SSM_HOLD && req_s2 && !req_cutoff && !req_s1)
		|=> standstill_hold_o && !torque_cutoff_o && status_word_o[STAT_TORQUE_ON])
		else $error("hold removed torque");
	a_hold_entry: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_r == SSM_STOP2 && s2_end && !req_cutoff && !req_s1 && !fail) |=> standstill_hold_o)
		else $error("stop hold did not enter hold");
	a_error_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(err_stop_r && !(state_r == SSM_CUTOFF && restart_ack_i)) |=> err_stop_r)
		else $error("error stop ended early");
	a_mode0_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_r == SSM_STOP1 && !s1_mode_r && !time_up && !req_cutoff && !ramp_fail)
		|=> !torque_cutoff_o)
		else $error("mode 0 cut before time");
	a_ramp_error: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ramp_fail |=> error_o)
		else $error("ramp fault not flagged");
	a_restart_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_r == SSM_CUTOFF && !time_done_r) |=> torque_cutoff_o)
		else $error("restart before stop time");
	a_bus_view: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(psel_i && !penable_i && !pwrite_i && hit_bits) |=> prdata_o[3:0] == $past(bus_bits_i))
		else $error("bus bit view altered");
endmodule : ssm_safe_stop_monitor

//--- tb/ssm_bus_partner.sv
// Safety controller model driving the stop bits and the drive feedback
`timescale 1ns/1ns
module ssm_bus_partner
(
	// Clock
	input wire logic sys_clk_i,
	// Commands from the bench
	input wire ssm_pkg::ssm_bus_bits_t cmd_bits_i,
	input wire ssm_pkg::ssm_drive_t cmd_drive_i,
	// Toward the monitor
	output ssm_pkg::ssm_bus_bits_t bus_bits_o,
	output ssm_pkg::ssm_drive_t drive_o
);
	import ssm_pkg::*;
	// Frames land on the clock edge, like a real bus cycle, never mid-cycle
	always_ff @(posedge sys_clk_i)
	begin
		bus_bits_o <= cmd_bits_i;
		drive_o <= cmd_drive_i;
	end
endmodule : ssm_bus_partner

//--- tb/ssm_safe_stop_monitor_bench.sv
// Self-checking bench for the safe stop monitor
`timescale 1ns/1ns
module ssm_safe_stop_monitor_bench;
	import ssm_pkg::*;
	typedef struct packed {logic w; logic [15:0] idx; logic [31:0] wd; logic [31:0] ed; logic ee;} ssm_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic err_req = 1'b0;
	logic ack = 1'b0;
	ssm_bus_bits_t bits = '0;
	ssm_drive_t drv = '0;
	ssm_bus_bits_t bus_bits;
	ssm_drive_t drive;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire cutoff;
	wire hold;
	wire err;
	wire restart_ok;
	wire [15:0] status;
	wire [4:0] mon = {cutoff, hold, err, status[0], status[15]};
	logic [31:0] rd;
	logic er;
	int bad_count = 0;
	int cmp_count = 0;
	ssm_row_t rows [12] = '{
		'{1'b1, REG_STOP_TIME, 32'h0000_0005, 32'h0000_0000, 1'b1},
		'{1'b0, REG_STOP_TIME, 32'h0000_0000, 32'h0000_03e8, 1'b0},
		'{1'b0, REG_ENC_RESP, 32'h0000_0000, 32'h0000_000c, 1'b0},
		'{1'b0, REG_SPD_WIN, 32'h0000_0000, 32'h0000_000a, 1'b0},
		'{1'b0, REG_S1_SRC, 32'h0000_0000, 32'h0000_0001, 1'b0},
		'{1'b0, REG_S1_DELAY, 32'h0000_0000, 32'h0000_000a, 1'b0},
		'{1'b1, REG_PARAM_UNLOCK, UNLOCK_KEY, 32'h0000_0000, 1'b0},
		'{1'b1, REG_ENC_RESP, 32'h0000_000d, 32'h0000_0000, 1'b1},
		'{1'b1, REG_ENC_RESP, 32'h0000_0064, 32'h0000_0000, 1'b0},
		'{1'b0, REG_ENC_RESP, 32'h0000_0000, 32'h0000_0064, 1'b0},
		'{1'b1, REG_BUS_BITS, 32'h0000_0001, 32'h0000_0000, 1'b1},
		'{1'b0, 16'h2000, 32'h0000_0000, 32'h0000_0000, 1'b1}
	};

	ssm_bus_partner i_partner (.sys_clk_i(clk), .cmd_bits_i(bits), .cmd_drive_i(drv),
		.bus_bits_o(bus_bits), .drive_o(drive));
	ssm_safe_stop_monitor i_dut (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .bus_bits_i(bus_bits), .error_stop_req_i(err_req), .drive_i(drive),
		.restart_ack_i(ack), .torque_cutoff_o(cutoff), .standstill_hold_o(hold), .error_o(err),
		.restart_ok_o(restart_ok), .status_word_o(status));

	initial
	begin
		forever #5 clk = ~clk;
	end

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Holds the request until pready is sampled high at an edge
	task apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		chk("pready", 32'h0000_0001, {31'd0, pready});
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wait_mon(input int b, input logic v, input string nm);
		int n;
		n = 0;
		while (mon[b] !== v && n < 16)
		begin
			@(posedge clk);
			n++;
		end
		chk(nm, {31'd0, v}, {31'd0, mon[b]});
	endtask : wait_mon

	task do_reset;
		bits <= '0;
		drv <= '{16'h0064, 1'b0, 1'b0};
		err_req <= 1'b0;
		ack <= 1'b0;
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset

	task cfg(input logic [15:0] idx, input logic [31:0] val);
		apb(1'b1, REG_PARAM_UNLOCK, UNLOCK_KEY);
		apb(1'b1, idx, val);
		chk("config write", 32'h0000_0000, {31'd0, er});
	endtask : cfg

	task test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	initial
	begin
		#(30_000 * 10);
		bad_count++;
		test_done();
	end

	initial
	begin
		do_reset();
		@(posedge clk);
		chk("status after reset", 32'h0000_8000, {16'h0000, status});
		foreach (rows[i])
		begin
			apb(rows[i].w, rows[i].idx, rows[i].wd);
			chk("pslverr", {31'd0, rows[i].ee}, {31'd0, er});
			if (!rows[i].w && !rows[i].ee)
				chk("prdata", rows[i].ed, rd);
		end
		$display("test register table done");
		cfg(REG_S1_MODE, 32'h0000_0001);
		bits <= 4'h4;
		wait_mon(1, 1'b1, "stop one active");
		apb(1'b0, REG_BUS_BITS, 32'h0000_0000);
		chk("bus view", 32'h0000_0004, rd);
		repeat (8) @(posedge clk);
		chk("torque kept while moving", 32'h0000_0001, {31'd0, mon[0]});
		drv <= '{16'h0005, 1'b0, 1'b0};
		wait_mon(4, 1'b1, "cutoff at standstill");
		wait_mon(0, 1'b0, "torque status cleared");
		bits <= 4'h0;
		ack <= 1'b1;
		repeat (8) @(posedge clk);
		chk("no restart before stop time", 32'h0000_0001, {31'd0, cutoff});
		chk("restart not offered", 32'h0000_0000, {31'd0, restart_ok});
		$display("test standstill cutoff done");
		do_reset();
		cfg(REG_S2_MODE, 32'h0000_0001);
		bits <= 4'h2;
		repeat (8) @(posedge clk);
		chk("no hold while moving", 32'h0000_0000, {31'd0, hold});
		drv <= '{16'h0003, 1'b0, 1'b0};
		wait_mon(3, 1'b1, "hold at standstill");
		chk("hold keeps torque", 32'h0000_0001, {31'd0, mon[0]});
		bits <= 4'ha;
		wait_mon(4, 1'b1, "cutoff wins");
		wait_mon(3, 1'b0, "hold aborted");
		$display("test stop hold and priority done");
		do_reset();
		cfg(REG_S1_SRC, 32'h0000_0000);
		bits <= 4'h4;
		repeat (8) @(posedge clk);
		chk("bus source off", 32'h0000_0000, {31'd0, mon[1]});
		bits <= 4'h5;
		wait_mon(1, 1'b1, "emergency start");
		do_reset();
		err_req <= 1'b1;
		wait_mon(1, 1'b1, "error stop start");
		$display("test stop sources done");
		do_reset();
		cfg(REG_ENC_CFG, 32'h0000_0001);
		cfg(REG_RAMP, 32'h0000_0001);
		bits <= 4'h4;
		drv <= '{16'h00c8, 1'b0, 1'b1};
		wait_mon(2, 1'b1, "ramp error");
		bits <= 4'h0;
		drv <= '{16'h00c8, 1'b0, 1'b0};
		repeat (10) @(posedge clk);
		chk("error kept", 32'h0000_0001, {31'd0, err});
		wait_mon(4, 1'b1, "error stop cutoff");
		$display("test error stop done");
		do_reset();
		cfg(REG_STOP_TIME, 32'h0000_0000);
		bits <= 4'h4;
		wait_mon(4, 1'b1, "timeout cutoff");
		chk("timeout error", 32'h0000_0001, {31'd0, err});
		bits <= 4'h0;
		repeat (8) @(posedge clk);
		chk("no restart without ack", 32'h0000_0001, {31'd0, cutoff});
		ack <= 1'b1;
		wait_mon(4, 1'b0, "acknowledged restart");
		chk("restart offered", 32'h0000_0001, {31'd0, restart_ok});
		chk("error cleared by ack", 32'h0000_0000, {31'd0, err});
		ack <= 1'b0;
		cfg(REG_RESTART, 32'h0000_0001);
		drv <= '{16'h0005, 1'b0, 1'b0};
		bits <= 4'h4;
		wait_mon(4, 1'b1, "cutoff after stop time");
		chk("no error at standstill", 32'h0000_0000, {31'd0, err});
		bits <= 4'h0;
		wait_mon(4, 1'b0, "automatic restart");
		$display("test stop time and restart done");
		test_done();
	end
endmodule : ssm_safe_stop_monitor_bench
